// ==== src/tprc_pkg.sv ====
package tprc_pkg;

	// ------------------------------------------------------------------
	// Clock rates and measurement timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_HZ     = 100_000_000;
	localparam int unsigned MEAS_HZ    = 12_000_000;
	// Resolution of one measurement count, in ns.
	localparam int unsigned RES_NS     = 83;
	// Fractional divider: add STEP each aclk, wrap at MOD, tick on wrap.
	localparam logic [7:0]  ACC_MOD    = 8'(CLK_HZ / 1_000_000);
	localparam logic [7:0]  ACC_STEP   = 8'(MEAS_HZ / 1_000_000);

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_STATUS = 8'h04;
	localparam logic [7:0]  OFS_PERIOD = 8'h08;
	localparam logic [7:0]  OFS_RDBK   = 8'h0C;

	// ------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------
	localparam int unsigned CTRL_W     = 6;
	localparam int unsigned CTRL_DAOUT = 0;
	localparam int unsigned CTRL_RDBK  = 1;
	localparam int unsigned CTRL_TACH  = 2;
	localparam int unsigned CTRL_RISE  = 3;
	localparam int unsigned CTRL_STALE = 4;
	localparam int unsigned CTRL_RCLR  = 5;
	localparam logic [5:0]  CTRL_RST   = 6'h00;

	// ------------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------------
	localparam int unsigned STAT_OVR   = 0;
	localparam int unsigned STAT_FRESH = 1;
	localparam int unsigned STAT_DONE  = 2;

	// ------------------------------------------------------------------
	// Bus answers, stream channels and sequencer states
	// ------------------------------------------------------------------
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TPRC_CH_RDBK = 2'b00,
		TPRC_CH_TACH = 2'b01
	} tprc_chan_t;

	typedef enum logic [1:0] {
		EM_IDLE = 2'b00,
		EM_RDBK = 2'b01,
		EM_TACH = 2'b10
	} tprc_emit_t;

endpackage : tprc_pkg

// ==== src/tprc_top.sv ====
// Overview of operation
// - Analog output data is driven only while its output enable is set.
// - With read-back on, the output value is inserted into the input stream.
// - The read-back value is sampled at the same instant as each scan.
// - Read-back follows the scan trigger and clock like any input channel.
// - Tachometer period is counted in ticks of an internal 12 MHz clock.
// - Tachometer value enters the stream only while tachometer enable is on.
// - Period runs rising to rising or falling to falling, as selected.
// - With stale indicator on, MSB is 0 for fresh data, 1 for old.
// - With stale indicator on, a value sampled before a measurement completes carries MSB 1.
// - With stale indicator off, the reported MSB is always 0.
// - Read-and-clear zeroes reported value between measurements, else holds.
// - Tachometer value is captured at the same instant as each scan.
// - Tachometer channel follows the scan trigger and clock options.
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps

module tprc_fifo #(
	parameter int unsigned WIDTH = 34,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	// Shift buffer: slot 0 is the head, so the output is a flip-flop.
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [DEPTH-1:0] vld_q;
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [DEPTH-1:0] vld_d;
	logic             pop;
	logic             push;
	logic             placed;

	assign pop       = vld_q[0] & out_ready;
	assign push      = in_valid & ~vld_q[DEPTH-1];
	assign in_ready  = ~vld_q[DEPTH-1];
	assign out_valid = vld_q[0];
	assign out_data  = mem_q[0];

	always_comb begin
		placed = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			if (pop) begin
				vld_d[i] = (i < DEPTH - 1) ? vld_q[(i + 1) % DEPTH] : 1'b0;
				mem_d[i] = (i < DEPTH - 1) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
			end else begin
				vld_d[i] = vld_q[i];
				mem_d[i] = mem_q[i];
			end
			if (push && !placed && !vld_d[i]) begin
				vld_d[i] = 1'b1;
				mem_d[i] = in_data;
				placed   = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vld_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			vld_q <= vld_d;
			mem_q <= mem_d;
		end
	end

endmodule : tprc_fifo

module tprc_top #(
	parameter int unsigned DAC_W  = 16,
	parameter int unsigned TACH_W = 31,
	parameter int unsigned BUF_D  = 2
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              tach_in,
	input  wire logic [DAC_W-1:0]  dac_value,
	output logic [DAC_W-1:0]       dac_out_data,
	output logic                   dac_out_en,
	input  wire logic              scan_strobe,
	output logic                   m_tvalid,
	input  wire logic              m_tready,
	output logic [31:0]            m_tdata,
	output logic [1:0]             m_tuser,
	output logic                   overrun
);
	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	logic [5:0]        ctrl_q;
	logic              ovr_q;
	logic              aw_v_q;
	logic [7:0]        aw_a_q;
	logic              w_v_q;
	logic [31:0]       w_d_q;
	logic [3:0]        w_s_q;
	logic              awready_q;
	logic              wready_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              arready_q;
	logic              rvalid_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              aw_take;
	logic              w_take;
	logic              wr_go;
	logic              aw_v_d;
	logic              w_v_d;
	logic              bvalid_d;
	logic              ar_go;
	logic              rvalid_d;
	logic              wr_ctrl;
	logic              wr_stat;
	logic              wr_hit;
	logic              rd_hit;
	logic [31:0]       rd_mux;
	logic              ovr_set;

	// Tachometer and stream state, declared here for the read mux.
	logic [TACH_W-1:0] period_q;
	logic              fresh_q;
	logic              done_q;
	logic [DAC_W-1:0]  rb_hold_q;

	assign aw_take  = s_axi_awvalid & awready_q;
	assign w_take   = s_axi_wvalid & wready_q;
	assign wr_go    = aw_v_q & w_v_q & ~bvalid_q;
	assign aw_v_d   = (aw_v_q | aw_take) & ~wr_go;
	assign w_v_d    = (w_v_q | w_take) & ~wr_go;
	assign bvalid_d = wr_go | (bvalid_q & ~s_axi_bready);
	assign wr_hit   = (aw_a_q[7:2] == tprc_pkg::OFS_CTRL[7:2]) |
	                  (aw_a_q[7:2] == tprc_pkg::OFS_STATUS[7:2]);
	assign wr_ctrl  = wr_go & w_s_q[0] &
	                  (aw_a_q[7:2] == tprc_pkg::OFS_CTRL[7:2]);
	assign wr_stat  = wr_go & w_s_q[0] &
	                  (aw_a_q[7:2] == tprc_pkg::OFS_STATUS[7:2]);
	assign ar_go    = s_axi_arvalid & arready_q;
	assign rvalid_d = ar_go | (rvalid_q & ~s_axi_rready);
	assign rd_hit   = s_axi_araddr[7:4] == 4'h0;
	assign rd_mux   =
		(s_axi_araddr[7:2] == tprc_pkg::OFS_CTRL[7:2])   ?
			{26'h0000000, ctrl_q} :
		(s_axi_araddr[7:2] == tprc_pkg::OFS_STATUS[7:2]) ?
			{29'h00000000, done_q, fresh_q, ovr_q} :
		(s_axi_araddr[7:2] == tprc_pkg::OFS_PERIOD[7:2]) ?
			32'(period_q) :
		(s_axi_araddr[7:2] == tprc_pkg::OFS_RDBK[7:2])   ?
			32'(rb_hold_q) : 32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_v_q    <= 1'b0;
			aw_a_q    <= 8'h00;
			w_v_q     <= 1'b0;
			w_d_q     <= 32'h00000000;
			w_s_q     <= 4'h0;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= tprc_pkg::RESP_OKAY;
		end else begin
			aw_v_q    <= aw_v_d;
			w_v_q     <= w_v_d;
			awready_q <= ~aw_v_d & ~bvalid_d;
			wready_q  <= ~w_v_d & ~bvalid_d;
			bvalid_q  <= bvalid_d;
			if (aw_take) begin
				aw_a_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_d_q <= s_axi_wdata;
				w_s_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				bresp_q <= wr_hit ? tprc_pkg::RESP_OKAY : tprc_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= tprc_pkg::RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q  <= rvalid_d;
			if (ar_go) begin
				rdata_q <= rd_mux;
				rresp_q <= rd_hit ? tprc_pkg::RESP_OKAY : tprc_pkg::RESP_SLVERR;
			end
		end
	end

	// Overrun is write-one-to-clear; a new overrun in the same cycle wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= tprc_pkg::CTRL_RST;
			ovr_q  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= w_d_q[5:0];
			end
			if (ovr_set) begin
				ovr_q <= 1'b1;
			end else if (wr_stat && w_d_q[tprc_pkg::STAT_OVR]) begin
				ovr_q <= 1'b0;
			end
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign overrun       = ovr_q;

	// ------------------------------------------------------------------
	// Analog output gating
	// ------------------------------------------------------------------
	logic [DAC_W-1:0] dac_q;
	logic             dac_en_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dac_q    <= '0;
			dac_en_q <= 1'b0;
		end else begin
			dac_en_q <= ctrl_q[tprc_pkg::CTRL_DAOUT];
			dac_q    <= ctrl_q[tprc_pkg::CTRL_DAOUT] ? dac_value : '0;
		end
	end

	assign dac_out_data = dac_q;
	assign dac_out_en   = dac_en_q;

	// ------------------------------------------------------------------
	// Tachometer period measurement
	// ------------------------------------------------------------------
	logic [7:0]        acc_q;
	logic              tick;
	logic [7:0]        acc_sum;
	logic              t_meta_q;
	logic              t_sync_q;
	logic              t_prev_q;
	logic              edge_hit;
	logic [TACH_W-1:0] cnt_q;
	logic              armed_q;
	logic              tach_on;
	logic              scan_tach;

	assign acc_sum  = acc_q + tprc_pkg::ACC_STEP;
	assign tick     = acc_sum >= tprc_pkg::ACC_MOD;
	assign tach_on  = ctrl_q[tprc_pkg::CTRL_TACH];
	assign edge_hit = ctrl_q[tprc_pkg::CTRL_RISE] ?
	                  (t_sync_q & ~t_prev_q) : (~t_sync_q & t_prev_q);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q    <= 8'h00;
			t_meta_q <= 1'b0;
			t_sync_q <= 1'b0;
			t_prev_q <= 1'b0;
		end else begin
			acc_q    <= tick ? acc_sum - tprc_pkg::ACC_MOD : acc_sum;
			t_meta_q <= tach_in;
			t_sync_q <= t_meta_q;
			t_prev_q <= t_sync_q;
		end
	end

	// The first edge after enabling only arms; the count saturates.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q    <= '0;
			armed_q  <= 1'b0;
			period_q <= '0;
			fresh_q  <= 1'b0;
			done_q   <= 1'b0;
		end else if (!tach_on) begin
			cnt_q   <= '0;
			armed_q <= 1'b0;
			fresh_q <= 1'b0;
		end else if (edge_hit) begin
			// A tick in the edge cycle already belongs to the new period.
			cnt_q   <= TACH_W'(tick);
			armed_q <= 1'b1;
			if (armed_q) begin
				period_q <= cnt_q;
				fresh_q  <= 1'b1;
				done_q   <= 1'b1;
			end else if (scan_tach) begin
				fresh_q <= 1'b0;
			end
		end else begin
			if (tick && !(&cnt_q)) begin
				cnt_q <= cnt_q + 1'b1;
			end
			if (scan_tach) begin
				fresh_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Scan capture and stream insertion
	// ------------------------------------------------------------------
	tprc_pkg::tprc_emit_t state_q;
	tprc_pkg::tprc_emit_t state_d;
	logic [31:0]          tach_hold_q;
	logic                 tach_inc_q;
	logic [TACH_W-1:0]    tach_val;
	logic                 stale_bit;
	logic                 push_v;
	logic                 push_rdy;
	logic [33:0]          push_d;
	logic                 push_ok;
	logic [33:0]          buf_out;

	assign scan_tach = scan_strobe & tach_on;
	assign tach_val  = (ctrl_q[tprc_pkg::CTRL_RCLR] && !fresh_q) ?
	                   '0 : period_q;
	assign stale_bit = ctrl_q[tprc_pkg::CTRL_STALE] & ~fresh_q;
	assign ovr_set   = scan_strobe & (state_q != tprc_pkg::EM_IDLE);
	assign push_v    = (state_q == tprc_pkg::EM_RDBK) |
	                   (state_q == tprc_pkg::EM_TACH);
	assign push_ok   = push_v & push_rdy;
	assign push_d    = (state_q == tprc_pkg::EM_RDBK) ?
	                   {tprc_pkg::TPRC_CH_RDBK, 32'(rb_hold_q)} :
	                   {tprc_pkg::TPRC_CH_TACH, tach_hold_q};

	always_comb begin
		state_d = state_q;
		case (state_q)
			tprc_pkg::EM_IDLE: begin
				state_d = tprc_pkg::EM_IDLE;
			end
			tprc_pkg::EM_RDBK: begin
				if (push_ok) begin
					state_d = tach_inc_q ? tprc_pkg::EM_TACH : tprc_pkg::EM_IDLE;
				end
			end
			tprc_pkg::EM_TACH: begin
				if (push_ok) begin
					state_d = tprc_pkg::EM_IDLE;
				end
			end
			default: begin
				state_d = tprc_pkg::EM_IDLE;
			end
		endcase
		// A new scan restarts the sequence with freshly sampled values.
		if (scan_strobe) begin
			if (ctrl_q[tprc_pkg::CTRL_RDBK]) begin
				state_d = tprc_pkg::EM_RDBK;
			end else if (tach_on) begin
				state_d = tprc_pkg::EM_TACH;
			end else begin
				state_d = tprc_pkg::EM_IDLE;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q     <= tprc_pkg::EM_IDLE;
			rb_hold_q   <= '0;
			tach_hold_q <= 32'h00000000;
			tach_inc_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			if (scan_strobe) begin
				rb_hold_q   <= dac_value;
				tach_hold_q <= {stale_bit, tach_val};
				tach_inc_q  <= tach_on;
			end
		end
	end

	tprc_fifo #(
		.WIDTH (34),
		.DEPTH (BUF_D)
	) u_buf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (push_v),
		.in_ready  (push_rdy),
		.in_data   (push_d),
		.out_valid (m_tvalid),
		.out_ready (m_tready),
		.out_data  (buf_out)
	);

	assign m_tuser = buf_out[33:32];
	assign m_tdata = buf_out[31:0];

endmodule : tprc_top

// ==== testbench/tprc_properties.sv ====
`timescale 1ns/10ps
module tprc_properties #(
	parameter int unsigned DAC_W = 16
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic [DAC_W-1:0] dac_value,
	input wire logic [DAC_W-1:0] dac_out_data,
	input wire logic             dac_out_en,
	input wire logic             scan_strobe,
	input wire logic             m_tvalid,
	input wire logic             m_tready,
	input wire logic [31:0]      m_tdata,
	input wire logic [1:0]       m_tuser,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [31:0]      s_axi_rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_stall; m_tvalid && !m_tready; endsequence
	sequence s_bdone; s_axi_bvalid && s_axi_bready; endsequence
	sequence s_recent_scan;
		$past(scan_strobe) || $past(scan_strobe, 2) || $past(scan_strobe, 3);
	endsequence
	property p_dac_on;
		dac_out_en |-> dac_out_data == $past(dac_value);
	endproperty
	property p_dac_off; !dac_out_en |-> dac_out_data == '0; endproperty
	property p_hold;
		s_stall |=> m_tvalid && $stable(m_tdata) && $stable(m_tuser);
	endproperty
	property p_user;
		m_tvalid |-> m_tuser inside {tprc_pkg::TPRC_CH_RDBK,
			tprc_pkg::TPRC_CH_TACH};
	endproperty
	property p_align; $rose(m_tvalid) |-> s_recent_scan; endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_bdone;
		s_bdone |=> !s_axi_bvalid ##[0:1] s_axi_awready;
	endproperty
	a_dac_on: assert property (p_dac_on) else $error("dac data lags");
	a_dac_off: assert property (p_dac_off) else $error("dac drives");
	a_hold: assert property (p_hold) else $error("stream word moved");
	a_user: assert property (p_user) else $error("bad channel");
	a_align: assert property (p_align) else $error("word without scan");
	a_bhold: assert property (p_bhold) else $error("write answer moved");
	a_rhold: assert property (p_rhold) else $error("read answer moved");
	a_bdone: assert property (p_bdone) else $error("write not closed");
endmodule : tprc_properties

bind tprc_top tprc_properties #(.DAC_W(DAC_W)) u_props (
	.aclk(aclk), .aresetn(aresetn), .dac_value(dac_value),
	.dac_out_data(dac_out_data), .dac_out_en(dac_out_en),
	.scan_strobe(scan_strobe), .m_tvalid(m_tvalid), .m_tready(m_tready),
	.m_tdata(m_tdata), .m_tuser(m_tuser), .s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata)
);

// ==== testbench/tprc_tach_src.sv ====
`timescale 1ns/10ps
// Square wave of two half periods; the pin stands low while idle.
module tprc_tach_src (
	input wire logic        aclk,
	input wire logic        run,
	input wire logic [15:0] half,
	output logic            tach_in
);
	logic [15:0] cnt_q;
	always @(posedge aclk) begin
		if (!run) begin
			cnt_q <= 16'h0000;
			tach_in <= 1'b0;
		end else if (cnt_q >= half - 16'h0001) begin
			cnt_q <= 16'h0000;
			tach_in <= !tach_in;
		end else
			cnt_q <= cnt_q + 16'h0001;
	end
endmodule : tprc_tach_src

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  s_axi_awaddr;
	logic [7:0]  s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [31:0] s_axi_rdata;
	logic [31:0] m_tdata;
	logic [31:0] d;
	logic [31:0] rs;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp;
	logic [1:0]  s_axi_rresp;
	logic [1:0]  m_tuser;
	logic [15:0] dac_value;
	logic [15:0] dac_out_data;
	logic [15:0] src_half;
	logic [5:0]  ctrl;
	logic [33:0] exq[$];
	logic [33:0] exp_w;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, tach_in, dac_out_en, src_run;
	logic        scan_strobe, m_tvalid, m_tready, overrun, m_fresh;
	int          fails, checked, m_per, k;

	tprc_top dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.tach_in(tach_in), .dac_value(dac_value),
		.dac_out_data(dac_out_data), .dac_out_en(dac_out_en),
		.scan_strobe(scan_strobe), .m_tvalid(m_tvalid), .m_tready(m_tready),
		.m_tdata(m_tdata), .m_tuser(m_tuser), .overrun(overrun)
	);
	tprc_tach_src u_src (
		.aclk(aclk), .run(src_run), .half(src_half), .tach_in(tach_in)
	);

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		bit aw;
		bit w;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 0;
		w = 0;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) aw = 1;
			if (s_axi_wvalid && s_axi_wready) w = 1;
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end while (!(aw && w));
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er,
		output logic [31:0] v);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic setc(input logic [5:0] c);
		ctrl = c;
		wr(tprc_pkg::OFS_CTRL, {26'h0, c}, tprc_pkg::RESP_OKAY);
	endtask : setc

	// Model of one scan: words queued in stream order with stale/clear rules.
	task automatic scan();
		logic [31:0] tw;
		logic [15:0] v;
		@(posedge aclk);
		v = 16'(rnd());
		dac_value <= v;
		@(posedge aclk);
		scan_strobe <= 1'b1;
		tw = (ctrl[tprc_pkg::CTRL_RCLR] && !m_fresh) ? 32'h0 : m_per;
		tw[31] = ctrl[tprc_pkg::CTRL_STALE] && !m_fresh;
		if (ctrl[tprc_pkg::CTRL_RDBK])
			exq.push_back({tprc_pkg::TPRC_CH_RDBK, 16'h0000, v});
		if (ctrl[tprc_pkg::CTRL_TACH]) begin
			exq.push_back({tprc_pkg::TPRC_CH_TACH, tw});
			m_fresh = 0;
		end
		@(posedge aclk);
		scan_strobe <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask : scan

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	always @(posedge aclk)
		if (m_tvalid === 1'b1 && m_tready === 1'b1) begin
			exp_w = exq.size() ? exq.pop_front() : 'x;
			chk({m_tuser, m_tdata}, exp_w);
		end

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	initial begin
		#300_000;
		fails++;
		conclude();
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, scan_strobe, src_run} = '0;
		s_axi_wstrb = 4'hF;
		dac_value = 16'h0000;
		src_half = 16'h0000;
		m_tready = 1'b1;
		aresetn = 1'b0;
		rs = 32'hAECB9821;
		ctrl = 6'h00;
		m_per = 0;
		m_fresh = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(tprc_pkg::OFS_CTRL, tprc_pkg::RESP_OKAY, d);
		chk(d, 32'h0);
		wr(tprc_pkg::OFS_PERIOD, 32'h1, tprc_pkg::RESP_SLVERR);
		wr(8'h40, 32'h1, tprc_pkg::RESP_SLVERR);
		rd(8'h10, tprc_pkg::RESP_SLVERR, d);
		chk(d, 32'h0);
		setc(6'h01);
		rd(tprc_pkg::OFS_CTRL, tprc_pkg::RESP_OKAY, d);
		chk(d, 32'h1);
		chk(dac_out_en, 1'b1);
		chk(dac_out_data, dac_value);
		done("registers");
		setc(6'h02);
		@(posedge aclk);
		chk(dac_out_en, 1'b0);
		repeat (3) scan();
		done("readback");
		setc(6'h1C);
		scan();
		src_half <= 16'd250;
		src_run <= 1'b1;
		repeat (2200) @(posedge aclk);
		m_per = 60;
		m_fresh = 1;
		scan();
		scan();
		rd(tprc_pkg::OFS_PERIOD, tprc_pkg::RESP_OKAY, d);
		chk(d, 32'd60);
		setc(6'h0C);
		scan();
		setc(6'h2E);
		repeat (1100) @(posedge aclk);
		m_fresh = 1;
		scan();
		scan();
		done("tach");
		setc(6'h16);
		for (int i = 0; i < 5; i++) begin
			k = 2 + int'(rnd() % 32'h8);
			src_half <= 16'(25 * k);
			repeat (200 * k + 20) @(posedge aclk);
			m_per = 6 * k;
			m_fresh = 1;
			scan();
		end
		done("random periods");
		setc(6'h02);
		m_tready <= 1'b0;
		repeat (4) scan();
		exq.delete(2);
		chk(overrun, 1'b1);
		rd(tprc_pkg::OFS_STATUS, tprc_pkg::RESP_OKAY, d);
		chk(d[tprc_pkg::STAT_OVR], 1'b1);
		wr(tprc_pkg::OFS_STATUS, 32'h1, tprc_pkg::RESP_OKAY);
		chk(overrun, 1'b0);
		m_tready <= 1'b1;
		repeat (10) @(posedge aclk);
		chk(exq.size(), 0);
		done("stall and overrun");
		conclude();
	end
endmodule : tb_top
